/* File: axt_pkg.sv */
// Constants for the arithmetic extension transfer and step timing block.
// Assumes a 12-bit host whose bit 00 is the most significant bit.
// Overview of operation
// - Octal 7501 ORs quotient into working register
// - Fetch loads buffer bits 08-10 into opcode latch
// - Quotient-to-bus needs bits 05, 11, phase two
// - Working load strobe at third fetch pulse
// - Octal 7421 moves working register into quotient
// - Move enable: bits 11, 07 set, 04 clear
// - Working bits ANDed into quotient data inputs
// - Feedback suppressed while moving to quotient
// - Octal 7441 ORs step counter into working
// - Counter-to-bus needs bits 11, 06, phase two
// - Launch request from normalize or execute state
// - Launch pulse sets running, and step-active only if finish request high
// - Step pulse 350 ns after launch, recirculates
// - Running reclocked from step-active at tap
// - Step with DIV_STEP_OK_I high resets load flop, tap sets it
// - Load flop strobes quotient and counter loads
// - Quotient load at third pulse with bit 07
// - Extension decode needs fetch, operate, bits 03, 11
// - Finish request low clears step-active next step
package axt_pkg;

    localparam int DATA_W = 12;
    localparam int CNT_W = 5;
    localparam int OPC_W = 3;

    // Host bit 00 is the MSB, so host bit n sits at index 11 - n
    localparam int MB03 = 8;
    localparam int MB04 = 7;
    localparam int MB05 = 6;
    localparam int MB06 = 5;
    localparam int MB07 = 4;
    localparam int MB08 = 3;
    localparam int MB09 = 2;
    localparam int MB10 = 1;
    localparam int MB11 = 0;

    // Instruction codes (octal 7501, 7421, 7441)
    localparam logic [11:0] OPC_OR_QUOT = 12'hF41;
    localparam logic [11:0] OPC_MOVE_QUOT = 12'hF11;
    localparam logic [11:0] OPC_OR_CNT = 12'hF21;

    localparam logic [DATA_W-1:0] QUOT_RESET = 12'h000;
    localparam logic [OPC_W-1:0] OPC_RESET = 3'h0;

    // Delay chain figures in ns
    localparam int CLK_NS = 50;
    localparam int TAP_DELAY_NS = 250;
    localparam int AMP_DELAY_NS = 100;
    localparam int RECIRC_NS = 350;
    localparam int RUN_RECLOCK_NS = 450;
    localparam int LOAD_PULSE_NS = 100;

    // Step period rounds down, tap and pulse width round up
    localparam int STEP_CYC = (TAP_DELAY_NS + AMP_DELAY_NS) / CLK_NS;
    localparam int TAP_CYC =
        (RUN_RECLOCK_NS - RECIRC_NS + CLK_NS - 1) / CLK_NS;
    localparam int LOAD_W_CYC = (LOAD_PULSE_NS + CLK_NS - 1) / CLK_NS;

endpackage

/* File: axt_delay_chain.sv */
// Synchronous stand-in for the tapped recirculating delay line.
// Assumes start_i is a single-cycle pulse in the core clock domain.
`timescale 1ns/1ps
module axt_delay_chain
    import axt_pkg::*;
#(
    parameter int PERIOD = STEP_CYC,
    parameter int TAP = TAP_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    output logic raw_o,
    output logic tap_o
);

    logic busy;
    logic [7:0] cnt;
    logic [TAP-1:0] tap_sh;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            busy <= 1'b0;
            cnt <= 8'h00;
        end else if (start_i) begin
            busy <= 1'b1;
            cnt <= 8'h00;
        end else if (raw_o) begin
            busy <= 1'b0;
        end else if (busy) begin
            cnt <= cnt + 8'h01;
        end
    end

    assign raw_o = busy && (cnt == 8'(PERIOD - 1));

    // Second tap trails every emerging pulse, gated or not
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tap_sh <= '0;
        end else begin
            tap_sh <= {tap_sh[TAP-2:0], raw_o};
        end
    end

    assign tap_o = tap_sh[TAP-1];

endmodule // axt_delay_chain

/* File: axt_quot_reg.sv */
// Quotient register with per-bit gated transfer from the working register.
// Assumes load strobes are synchronous; the transfer strobe lasts one cycle and the step strobe two.
`timescale 1ns/1ps
module axt_quot_reg
    import axt_pkg::*;
#(
    parameter int W = DATA_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic xfer_load_i,
    input wire logic move_en_i,
    input wire logic [W-1:0] work_i,
    input wire logic step_load_i,
    input wire logic [W-1:0] step_data_i,
    output logic [W-1:0] quot_o
);

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    quot_o[g] <= QUOT_RESET[g];
                end else if (xfer_load_i) begin
                    quot_o[g] <= work_i[g] & move_en_i;
                end else if (step_load_i) begin
                    quot_o[g] <= step_data_i[g];
                end
            end
        end
    endgenerate

endmodule // axt_quot_reg

/* File: axt_transfer_step.sv */
// Transfer decode and step timing of the arithmetic extension.
// Assumes host timing inputs are synchronous to CORE_CLK_I and that
// the third fetch pulse lasts one clock.
`timescale 1ns/1ps
module axt_transfer_step
    import axt_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    input wire logic [DATA_W-1:0] MEMORY_BUFFER_I,
    input wire logic FETCH_STATE_I,
    input wire logic EXECUTE_STATE_I,
    input wire logic OPERATE_CLASS_DECODE_I,
    input wire logic OPERATE_PHASE_TWO_I,
    input wire logic FETCH_THIRD_PULSE_I,
    input wire logic [DATA_W-1:0] WORKING_REGISTER_I,
    input wire logic [CNT_W-1:0] STEP_COUNTER_I,
    input wire logic SHIFT_NEEDED_FLAG_INSTR_I,
    input wire logic SHIFT_NEEDED_FLAG_I,
    input wire logic CNT_LOAD_MEM_QUAL_I,
    input wire logic FINISH_REQUEST_N_I,
    input wire logic DIV_STEP_OK_I,
    input wire logic [DATA_W-1:0] QUOT_STEP_DATA_I,
    output logic EXT_INSTR_DECODE_O,
    output logic [OPC_W-1:0] OPCODE_LATCH_O,
    output logic QUOTIENT_TO_BUS_EN_O,
    output logic COUNTER_TO_BUS_EN_O,
    output logic WORK_REG_FEEDBACK_EN_O,
    output logic WORK_TO_QUOTIENT_EN_O,
    output logic WORK_REG_LOAD_O,
    output logic QUOTIENT_LOAD_O,
    output logic COUNTER_LOAD_O,
    output logic [DATA_W-1:0] BUS_CONTRIB_O,
    output logic [DATA_W-1:0] QUOTIENT_REGISTER_O,
    output logic LAUNCH_REQUEST_O,
    output logic LAUNCH_PULSE_O,
    output logic STEP_PULSE_O,
    output logic STEP_ACTIVE_O,
    output logic RUNNING_O
);

    logic [DATA_W-1:0] mbuf;
    logic ph_two;
    logic pulse3;
    logic ext_instr_decode;
    logic xfer_quot_load;
    logic launch_pulse;
    logic chain_start;
    logic raw_pulse;
    logic tap_pulse;
    logic step_pulse;
    logic step_active_ff;
    logic running_ff;
    logic load_pulse_ff;
    logic next_load_pulse_ff;
    logic [1:0] strobe_cnt;
    logic load_strobe;

    assign mbuf = MEMORY_BUFFER_I;
    assign ph_two = OPERATE_PHASE_TWO_I;
    assign pulse3 = FETCH_THIRD_PULSE_I;

    // ------------------------------------------------------------
    // Instruction decode and transfer enables
    // ------------------------------------------------------------

    assign ext_instr_decode = FETCH_STATE_I && OPERATE_CLASS_DECODE_I
        && mbuf[MB03] && mbuf[MB11];
    assign EXT_INSTR_DECODE_O = ext_instr_decode;

    assign QUOTIENT_TO_BUS_EN_O = mbuf[MB05] && mbuf[MB11] && ph_two;

    assign COUNTER_TO_BUS_EN_O = mbuf[MB06] && mbuf[MB11] && ph_two;

    assign WORK_TO_QUOTIENT_EN_O = mbuf[MB11] && mbuf[MB07] && !mbuf[MB04]
        && ph_two;

    assign WORK_REG_FEEDBACK_EN_O = ph_two && !WORK_TO_QUOTIENT_EN_O
        && !mbuf[MB04];

    assign WORK_REG_LOAD_O = pulse3 && FETCH_STATE_I
        && OPERATE_CLASS_DECODE_I;

    assign xfer_quot_load = pulse3 && mbuf[MB07] && ext_instr_decode;

    assign QUOTIENT_LOAD_O = xfer_quot_load || load_strobe;
    assign COUNTER_LOAD_O = load_strobe;

    // ------------------------------------------------------------
    // Opcode latch
    // ------------------------------------------------------------

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            OPCODE_LATCH_O <= OPC_RESET;
        end else if (pulse3 && ext_instr_decode) begin
            OPCODE_LATCH_O <= {mbuf[MB10], mbuf[MB09], mbuf[MB08]};
        end
    end

    // ------------------------------------------------------------
    // Bus contribution
    // ------------------------------------------------------------

    // Host ORs this into its working register, so no stale bits may survive:
    // rebuilt every cycle from the enabled quotient and step counter ORed together
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            BUS_CONTRIB_O <= '0;
        end else begin
            BUS_CONTRIB_O <=
                (QUOTIENT_TO_BUS_EN_O ? QUOTIENT_REGISTER_O : '0)
                | (COUNTER_TO_BUS_EN_O
                    ? {{(DATA_W-CNT_W){1'b0}}, STEP_COUNTER_I} : '0);
        end
    end

    // ------------------------------------------------------------
    // Quotient register
    // ------------------------------------------------------------

    axt_quot_reg #(
        .W(DATA_W)
    ) u_quot (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RESET_N_I),
        .xfer_load_i(xfer_quot_load),
        .move_en_i(WORK_TO_QUOTIENT_EN_O),
        .work_i(WORKING_REGISTER_I),
        .step_load_i(load_strobe),
        .step_data_i(QUOT_STEP_DATA_I),
        .quot_o(QUOTIENT_REGISTER_O)
    );

    // ------------------------------------------------------------
    // Launch
    // ------------------------------------------------------------

    assign LAUNCH_REQUEST_O = (SHIFT_NEEDED_FLAG_INSTR_I && SHIFT_NEEDED_FLAG_I)
        || (OPERATE_CLASS_DECODE_I && EXECUTE_STATE_I);

    assign launch_pulse = LAUNCH_REQUEST_O && CNT_LOAD_MEM_QUAL_I && pulse3;
    assign LAUNCH_PULSE_O = launch_pulse;

    // ------------------------------------------------------------
    // Step chain
    // ------------------------------------------------------------

    // Only a gated step feeds the chain; an ungated one dies out
    assign chain_start = launch_pulse || step_pulse;

    axt_delay_chain #(
        .PERIOD(STEP_CYC),
        .TAP(TAP_CYC)
    ) u_chain (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RESET_N_I),
        .start_i(chain_start),
        .raw_o(raw_pulse),
        .tap_o(tap_pulse)
    );

    assign step_pulse = raw_pulse && running_ff;
    assign STEP_PULSE_O = step_pulse;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            step_active_ff <= 1'b0;
        end else if (launch_pulse) begin
            step_active_ff <= FINISH_REQUEST_N_I;
        end else if (step_pulse) begin
            step_active_ff <= FINISH_REQUEST_N_I || !running_ff;
        end
    end
    assign STEP_ACTIVE_O = step_active_ff;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            running_ff <= 1'b0;
        end else if (launch_pulse) begin
            running_ff <= 1'b1;
        end else if (tap_pulse) begin
            running_ff <= step_active_ff;
        end
    end
    assign RUNNING_O = running_ff;

    // ------------------------------------------------------------
    // Load pulse generator
    // ------------------------------------------------------------

    // reset by step with DIV_STEP_OK_I high, set by tap
    always_comb begin
        next_load_pulse_ff = load_pulse_ff;
        if (tap_pulse) begin
            next_load_pulse_ff = 1'b1;
        end else if (step_pulse) begin
            next_load_pulse_ff = !(DIV_STEP_OK_I && running_ff);
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            load_pulse_ff <= 1'b1;
        end else begin
            load_pulse_ff <= next_load_pulse_ff;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            strobe_cnt <= 2'h0;
        end else if (tap_pulse && !load_pulse_ff) begin
            strobe_cnt <= 2'(LOAD_W_CYC);
        end else if (strobe_cnt != 2'h0) begin
            strobe_cnt <= strobe_cnt - 2'h1;
        end
    end
    assign load_strobe = strobe_cnt != 2'h0;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    sequence s_launch;
        launch_pulse && FINISH_REQUEST_N_I;
    endsequence

    sequence s_first_step;
        running_ff ##6 step_pulse;
    endsequence

    sequence s_load_window;
        !load_pulse_ff [*2] ##1 (load_pulse_ff && COUNTER_LOAD_O);
    endsequence

    property p_or_quot;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (QUOTIENT_TO_BUS_EN_O && !COUNTER_TO_BUS_EN_O)
            |=> BUS_CONTRIB_O == $past(QUOTIENT_REGISTER_O);
    endproperty
    a_or_quot: assert property (p_or_quot)
        else $error("quotient not placed on bus");

    property p_opcode;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (pulse3 && ext_instr_decode) |=> OPCODE_LATCH_O ==
            {$past(mbuf[MB10]), $past(mbuf[MB09]), $past(mbuf[MB08])};
    endproperty
    a_opcode: assert property (p_opcode)
        else $error("opcode latch missed buffer bits");

    property p_quot_en;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        QUOTIENT_TO_BUS_EN_O |-> (mbuf[MB05] && mbuf[MB11] && ph_two);
    endproperty
    a_quot_en: assert property (p_quot_en)
        else $error("quotient enable without cause");

    property p_move;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (xfer_quot_load && WORK_TO_QUOTIENT_EN_O)
            |=> QUOTIENT_REGISTER_O == $past(WORKING_REGISTER_I);
    endproperty
    a_move: assert property (p_move)
        else $error("working value not moved to quotient");

    property p_no_feedback;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        WORK_TO_QUOTIENT_EN_O |-> !WORK_REG_FEEDBACK_EN_O;
    endproperty
    a_no_feedback: assert property (p_no_feedback)
        else $error("feedback on during move");

    property p_cnt_bus;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (ph_two && mbuf[MB11] && mbuf[MB06]) |=>
            BUS_CONTRIB_O[CNT_W-1:0] ==
            (BUS_CONTRIB_O[CNT_W-1:0] | $past(STEP_COUNTER_I));
    endproperty
    a_cnt_bus: assert property (p_cnt_bus)
        else $error("step counter missing from bus");

    property p_first_step;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        s_launch |=> s_first_step;
    endproperty
    a_first_step: assert property (p_first_step)
        else $error("no step pulse seven cycles after launch");

    property p_recirc;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (step_pulse && FINISH_REQUEST_N_I && step_active_ff)
            |-> ##7 step_pulse;
    endproperty
    a_recirc: assert property (p_recirc)
        else $error("step pulse did not recirculate");

    property p_stop;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (step_pulse && !FINISH_REQUEST_N_I && !launch_pulse)
            |=> !step_active_ff ##2 !running_ff;
    endproperty
    a_stop: assert property (p_stop)
        else $error("finish did not shut the chain");

    property p_load_pulse;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (step_pulse && DIV_STEP_OK_I) |=> s_load_window;
    endproperty
    a_load_pulse: assert property (p_load_pulse)
        else $error("load flop not reset then set");

    property p_strobe;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        $rose(COUNTER_LOAD_O) |-> QUOTIENT_LOAD_O [*2]
            ##1 !COUNTER_LOAD_O;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("load strobe width wrong");

    property p_decode;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        ext_instr_decode |-> (FETCH_STATE_I && mbuf[MB03] && mbuf[MB11]);
    endproperty
    a_decode: assert property (p_decode)
        else $error("decode outside extension fetch");

endmodule // axt_transfer_step

/* File: axt_host_model.sv */
// Host fetch/execute timing, memory buffer and working register model.
// Assumes one go pulse per instruction, issued only while idle.
`timescale 1ns/1ps
module axt_host_model
    import axt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic go_i,
    input wire logic exec_mode_i,
    input wire logic [DATA_W-1:0] instr_i,
    input wire logic [DATA_W-1:0] work_seed_i,
    input wire logic work_load_i,
    input wire logic feedback_en_i,
    input wire logic [DATA_W-1:0] bus_i,
    output logic fetch_o,
    output logic exec_o,
    output logic oper_o,
    output logic ph_two_o,
    output logic pulse3_o,
    output logic [DATA_W-1:0] mbuf_o,
    output logic [DATA_W-1:0] work_o
);
    logic [1:0] ph;
    logic mode;

    // ----
    // Cycle sequencer: setup, phase two, phase two with third pulse
    // ----
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ph <= 2'h0;
            mode <= 1'b0;
        end else if (go_i && ph == 2'h0) begin
            ph <= 2'h1;
            mode <= exec_mode_i;
        end else if (ph != 2'h0) begin
            ph <= ph + 2'h1;
        end
    end

    assign fetch_o = (ph != 2'h0) && !mode;
    assign exec_o = (ph != 2'h0) && mode;
    assign oper_o = ph != 2'h0;
    assign ph_two_o = fetch_o && ph >= 2'h2;
    assign pulse3_o = ph == 2'h3;

    // Released buffer toggles so a stale value never looks valid
    always_ff @(posedge clk_i) begin
        if (!rst_n_i)
            mbuf_o <= 12'h000;
        else if (go_i && ph == 2'h0)
            mbuf_o <= instr_i;
        else if (ph == 2'h0)
            mbuf_o <= ~mbuf_o;
    end

    always_ff @(posedge clk_i) begin
        if (go_i && ph == 2'h0 && !exec_mode_i)
            work_o <= instr_i[MB04] ? 12'h000 : work_seed_i;
        else if (work_load_i)
            work_o <= (feedback_en_i ? work_o : 12'h000) | bus_i;
    end
endmodule // axt_host_model

/* File: axt_transfer_step_tb.sv */
// Self-checking bench for the transfer decode and step timing block.
// Assumes the host model drives all fetch/execute timing inputs.
`timescale 1ns/1ps
module axt_transfer_step_tb;
    import axt_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic go = 1'b0;
    logic exec_mode = 1'b0;
    logic shift_needed_flag = 1'b0;
    logic shift = 1'b0;
    logic qual = 1'b0;
    logic fin_n = 1'b1;
    logic div_ok = 1'b1;
    logic [DATA_W-1:0] instr = 12'h000;
    logic [DATA_W-1:0] seed = 12'h000;
    logic [DATA_W-1:0] sdata = 12'h000;
    logic [DATA_W-1:0] q_m = QUOT_RESET;
    logic [OPC_W-1:0] op_m = OPC_RESET;
    logic [CNT_W-1:0] cnt = 5'h00;
    logic fetch, exe, oper, ph_two, pulse3, xd, qe, ce, w2q, fb, wld, ql, cl;
    logic req, lp, stp, act, run;
    logic [DATA_W-1:0] mbuf, work, bus, quot;
    logic [OPC_W-1:0] opc;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;

    axt_host_model i_host (.clk_i(clk), .rst_n_i(rst_n), .go_i(go),
        .exec_mode_i(exec_mode), .instr_i(instr), .work_seed_i(seed),
        .work_load_i(wld), .feedback_en_i(fb), .bus_i(bus), .fetch_o(fetch),
        .exec_o(exe), .oper_o(oper), .ph_two_o(ph_two), .pulse3_o(pulse3),
        .mbuf_o(mbuf), .work_o(work));

    axt_transfer_step i_dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
        .MEMORY_BUFFER_I(mbuf), .FETCH_STATE_I(fetch), .EXECUTE_STATE_I(exe),
        .OPERATE_CLASS_DECODE_I(oper), .OPERATE_PHASE_TWO_I(ph_two),
        .FETCH_THIRD_PULSE_I(pulse3), .WORKING_REGISTER_I(work),
        .STEP_COUNTER_I(cnt), .SHIFT_NEEDED_FLAG_INSTR_I(shift_needed_flag), .SHIFT_NEEDED_FLAG_I(shift),
        .CNT_LOAD_MEM_QUAL_I(qual), .FINISH_REQUEST_N_I(fin_n),
        .DIV_STEP_OK_I(div_ok), .QUOT_STEP_DATA_I(sdata),
        .EXT_INSTR_DECODE_O(xd), .OPCODE_LATCH_O(opc),
        .QUOTIENT_TO_BUS_EN_O(qe), .COUNTER_TO_BUS_EN_O(ce),
        .WORK_REG_FEEDBACK_EN_O(fb), .WORK_TO_QUOTIENT_EN_O(w2q),
        .WORK_REG_LOAD_O(wld), .QUOTIENT_LOAD_O(ql), .COUNTER_LOAD_O(cl),
        .BUS_CONTRIB_O(bus), .QUOTIENT_REGISTER_O(quot),
        .LAUNCH_REQUEST_O(req), .LAUNCH_PULSE_O(lp), .STEP_PULSE_O(stp),
        .STEP_ACTIVE_O(act), .RUNNING_O(run));

    always #25 clk = ~clk;

    // Whole run is well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end

    // ----
    // Compare and closing tasks
    // ----
    task automatic chk_bit(input logic got, input logic exp, input string s);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: %s got %b exp %b", $time, s, got, exp);
        end
    endtask

    task automatic chk_word(input logic [DATA_W-1:0] got,
                            input logic [DATA_W-1:0] exp, input string s);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: %s got %h exp %h", $time, s, got, exp);
        end
    endtask

    task automatic stop_test();
        if (n_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Start one host cycle and stop at the negedge of its third pulse
    task automatic issue(input logic [DATA_W-1:0] w, input logic ex,
                         input logic qv);
        @(posedge clk);
        go <= 1'b1;
        exec_mode <= ex;
        instr <= w;
        qual <= qv;
        seed <= 12'($urandom);
        cnt <= 5'($urandom);
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            if (pulse3 === 1'b1)
                break;
        end
        chk_bit(pulse3, 1'b1, "third pulse");
    endtask

    // ----
    // Single-cycle transfer
    // ----
    task automatic do_xfer(input logic [DATA_W-1:0] w);
        logic eq, ec, em, ed;
        logic [DATA_W-1:0] eb, ew;
        issue(w, 1'b0, 1'($urandom));
        eq = w[MB05] & w[MB11];
        ec = w[MB06] & w[MB11];
        em = w[MB11] & w[MB07] & !w[MB04];
        ed = w[MB03] & w[MB11];
        eb = (eq ? q_m : 12'h000) | (ec ? {7'h00, cnt} : 12'h000);
        ew = ((w[MB04] | em) ? 12'h000 : seed) | eb;
        chk_bit(xd, ed, "decode");
        chk_bit(qe, eq, "quot bus en");
        chk_bit(ce, ec, "cnt bus en");
        chk_bit(w2q, em, "move en");
        chk_bit(fb, !w[MB04] & !em, "feedback en");
        chk_bit(wld, 1'b1, "work load");
        chk_bit(ql, w[MB07] & ed, "quot load");
        chk_bit(lp, 1'b0, "launch");
        chk_word(bus, eb, "bus");
        if (w[MB07] & ed)
            q_m = em ? seed : 12'h000;
        if (ed)
            op_m = {w[MB10], w[MB09], w[MB08]};
        @(negedge clk);
        chk_word(quot, q_m, "quot");
        chk_word(work, ew, "work");
        chk_word({9'h000, opc}, {9'h000, op_m}, "opcode");
    endtask

    // ----
    // Step chain: f steps then finish, step number bad refused
    // ----
    task automatic run_steps(input int f, input int bad, input logic nm);
        int d;
        logic ld;
        @(posedge clk);
        fin_n <= 1'b1;
        div_ok <= 1'b1;
        sdata <= 12'($urandom);
        shift_needed_flag <= nm;
        shift <= nm;
        // Shift_needed_flag launch uses a fetch word without decode
        issue(nm ? 12'hE01 : 12'hF01, !nm, 1'b1);
        chk_bit(req, 1'b1, "request");
        chk_bit(lp, 1'b1, "launch");
        for (int c = 1; c <= STEP_CYC * f + 12; c++) begin
            @(posedge clk);
            shift_needed_flag <= 1'b0;
            shift <= 1'b0;
            fin_n <= (c >= STEP_CYC * f) ? 1'b0 : 1'b1;
            div_ok <= (c == STEP_CYC * bad) ? 1'b0 : 1'b1;
            @(negedge clk);
            d = c - TAP_CYC - 1;
            ld = d >= STEP_CYC && d % STEP_CYC < LOAD_W_CYC &&
                 d / STEP_CYC <= f && d / STEP_CYC != bad;
            chk_bit(stp, c <= STEP_CYC * f && !(c % STEP_CYC), "step");
            chk_bit(run, c <= STEP_CYC * f + 2, "running");
            chk_bit(act, c <= STEP_CYC * f, "active");
            chk_bit(cl, ld, "cnt load");
            chk_bit(ql, ld, "step quot load");
        end
        q_m = sdata;
        chk_word(quot, q_m, "step quot");
    endtask

    // ----
    // Main sequence
    // ----
    initial begin
        logic [DATA_W-1:0] w;
        logic [DATA_W-1:0] corner [8];
        corner = '{OPC_MOVE_QUOT, OPC_OR_QUOT, OPC_OR_CNT, 12'hF81,
                   12'hFC1, 12'hFA1, 12'hF51, 12'hF01};
        void'($urandom(32'h067D));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk_word(quot, QUOT_RESET, "reset quot");
        chk_word({9'h000, opc}, {9'h000, OPC_RESET}, "reset opcode");
        chk_bit(run, 1'b0, "reset running");
        chk_bit(cl, 1'b0, "reset cnt load");
        foreach (corner[i])
            do_xfer(corner[i]);
        for (int i = 0; i < 60; i++) begin
            w = {4'hF, 7'($urandom), 1'b1};
            if ($urandom_range(7) == 0)
                w[MB03] = 1'b0;
            if ($urandom_range(7) == 0)
                w[MB11] = 1'b0;
            do_xfer(w);
        end
        run_steps(4, 2, 1'b0);
        run_steps(3, 0, 1'b1);
        // Launch refused without the counter-load qualifier
        issue(12'hF01, 1'b1, 1'b0);
        chk_bit(lp, 1'b0, "launch no qual");
        repeat (STEP_CYC + 1) @(negedge clk);
        chk_bit(run, 1'b0, "running no qual");
        do_xfer(OPC_OR_QUOT);
        stop_test();
    end
endmodule // axt_transfer_step_tb
